// *** pfs_fault_strap_ctrl.sv ***
// Strap capture, switching protection, fault latches, interrupts and thermal trip shutdown.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pfs_fault_strap_ctrl
   import pfs_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic CHIP_ENABLE_IN,
   input wire logic [2:0] CURRENT_SET_STRAP,
   input wire logic [2:0] OUTPUT_SENSE_STRAP,
   input wire logic MEMORY_RAIL_SEL_HI,
   input wire logic MEMORY_RAIL_SEL_LO,
   input wire logic [5:0] PWM_ON,
   input wire logic [5:0] VALLEY_OVER,
   input wire logic [5:0] NEG_LIMIT,
   input wire logic [5:0] AT_TARGET,
   input wire logic [5:0] UV_CMP,
   input wire logic [5:0] OV_CMP,
   input wire logic [5:0] PG_IN,
   input wire logic TEMP_HOT,
   input wire logic TEMP_COOL,
   input wire logic TERM_REQ,
   input wire logic TERM_UV_CMP,
   input wire logic LSW_REQ,
   input wire logic SLEEP_STATE_IN,
   input wire logic THERMAL_TRIP_N,
   input wire logic SUSPEND_READY,
   input wire logic POWER_OK_REQ,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output wire logic [5:0] HS_ON,
   output wire logic [5:0] LS_ON,
   output wire logic [5:0] BUCK_EN,
   output wire logic [5:0] PGOOD_OUT,
   output logic [1:0] MEMORY_RAIL_VSEL,
   output logic TERM_EN,
   output logic [7:0] TERM_RAMP,
   output logic TERM_DISCHARGE,
   output logic LSW_EN,
   output logic [7:0] LSW_RAMP,
   output logic LSW_DISCHARGE,
   output logic SUSPEND_RESET_OUT_N,
   output logic PLATFORM_POWER_OK,
   output logic IRQ_N
);
   localparam int SW = 56;

   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic [5:0] pwm_s, valley_s, neg_s, tgt_s, uv_s, ov_s, pg_s;
   logic [2:0] cs_s, os_s;
   logic sel_hi_s, sel_lo_s, hot_s, cool_s, term_uv_s, trip_n_s, ce_s, sleep_s;
   logic ce_d_r;
   logic ce_rise;
   logic [5:0] strap_dis_r;
   logic otp_r;
   logic term_uv_r;
   logic trip_d_r;
   logic armed_r;
   logic trip_r;
   logic shut_r;
   logic trip_fall;
   logic [DIV_W-1:0] div_r;
   logic tick_r;
   logic [5:0] ctrl_r;
   logic [14:0] irq_r;
   logic [14:0] irq_nxt;
   logic [14:0] irq_clr;
   logic [5:0] uv_lat, ov_lat, uv_ev, ov_ev;
   logic gate_ok;
   logic term_run;
   logic lsw_run;
   logic bus_req;
   logic [31:0] wmask;

   // Every analog comparator and external pin except TERM_REQ, LSW_REQ, SUSPEND_READY, POWER_OK_REQ and the bus crosses two flops before use.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {PWM_ON, VALLEY_OVER, NEG_LIMIT, AT_TARGET, UV_CMP, OV_CMP, PG_IN,
                     CURRENT_SET_STRAP, OUTPUT_SENSE_STRAP, MEMORY_RAIL_SEL_HI,
                     MEMORY_RAIL_SEL_LO, TEMP_HOT, TEMP_COOL, TERM_UV_CMP,
                     THERMAL_TRIP_N, CHIP_ENABLE_IN, SLEEP_STATE_IN};
         sync2_r <= sync1_r;
      end
   end
   assign {pwm_s, valley_s, neg_s, tgt_s, uv_s, ov_s, pg_s, cs_s, os_s, sel_hi_s, sel_lo_s,
           hot_s, cool_s, term_uv_s, trip_n_s, ce_s, sleep_s} = sync2_r;

   assign ce_rise = ce_s & ~ce_d_r;

   // Straps are caught only at the enable rise, so later strap changes do nothing.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ce_d_r <= 1'b0;
         strap_dis_r <= 6'h00;
         MEMORY_RAIL_VSEL <= MEM_1V2;
      end else begin
         ce_d_r <= ce_s;
         if (ce_rise) begin
            strap_dis_r <= {cs_s[2], os_s[2:0], cs_s[1:0]};
            if (sel_hi_s) begin
               MEMORY_RAIL_VSEL <= MEM_1V35;
            end else if (sel_lo_s) begin
               MEMORY_RAIL_VSEL <= MEM_1V2;
            end else begin
               MEMORY_RAIL_VSEL <= MEM_1V1;
            end
         end
      end
   end

   // Over-temperature has hysteresis; hot wins if both comparators read active.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         otp_r <= 1'b0;
      end else if (hot_s) begin
         otp_r <= 1'b1;
      end else if (cool_s) begin
         otp_r <= 1'b0;
      end
   end

   // Thermal trip sequence: reset and power ok change first, rails follow two cycles later.
   assign trip_fall = armed_r & trip_d_r & ~trip_n_s;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         trip_d_r <= 1'b1;
         armed_r <= 1'b0;
         trip_r <= 1'b0;
         shut_r <= 1'b0;
         SUSPEND_RESET_OUT_N <= 1'b0;
         PLATFORM_POWER_OK <= 1'b0;
      end else begin
         trip_d_r <= trip_n_s;
         if (!ce_s) begin
            armed_r <= 1'b0;
            trip_r <= 1'b0;
            shut_r <= 1'b0;
         end else begin
            armed_r <= armed_r | SUSPEND_RESET_OUT_N;
            trip_r <= trip_r | trip_fall;
            shut_r <= shut_r | (trip_r & ~SUSPEND_RESET_OUT_N & ~PLATFORM_POWER_OK);
         end
         SUSPEND_RESET_OUT_N <= ce_s & SUSPEND_READY & ~trip_r & ~trip_fall;
         PLATFORM_POWER_OK <= ce_s & POWER_OK_REQ & ~trip_r & ~trip_fall;
      end
   end

   assign gate_ok = ce_s & ~otp_r & ~shut_r;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REG; gi++) begin : g_reg
         pfs_sw_t st_r;
         logic [TMR_W-1:0] tmr_r;
         logic [DG_W-1:0] uvc_r;
         logic [DG_W-1:0] ovc_r;
         logic uv_r, ov_r, hs_r, ls_r, en_r, pg_r;
         logic run, uv_trip, ov_trip;

         assign run = gate_ok & ~strap_dis_r[gi] & ~ctrl_r[gi] & ~uv_r & ~ov_r;
         assign uv_trip = uv_s[gi] & (uvc_r == UV_DG_LAST) & en_r;
         assign ov_trip = ov_s[gi] & (ovc_r == OV_DG_LAST) & en_r;

         // Deglitch counters only reach their end on an unbroken comparator level.
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               uvc_r <= '0;
               ovc_r <= '0;
            end else begin
               if (!uv_s[gi] || !en_r) begin
                  uvc_r <= '0;
               end else if (uvc_r != UV_DG_LAST) begin
                  uvc_r <= uvc_r + 1'b1;
               end
               if (!ov_s[gi] || !en_r) begin
                  ovc_r <= '0;
               end else if (ovc_r != OV_DG_LAST) begin
                  ovc_r <= ovc_r + 1'b1;
               end
            end
         end

         // Latches drop only with the enable low or the asynchronous supply reset.
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               uv_r <= 1'b0;
               ov_r <= 1'b0;
            end else if (!ce_s) begin
               uv_r <= 1'b0;
               ov_r <= 1'b0;
            end else begin
               if (uv_trip && st_r != PFS_OV_HOLD) begin
                  uv_r <= 1'b1;
               end
               if (st_r == PFS_OV_HOLD && tmr_r == OV_HOLD_LAST) begin
                  ov_r <= 1'b1;
               end
            end
         end

         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               st_r <= PFS_OFF;
               tmr_r <= '0;
               hs_r <= 1'b0;
               ls_r <= 1'b0;
            end else if (ov_trip && st_r != PFS_OV_HOLD && st_r != PFS_OFF) begin
               st_r <= PFS_OV_HOLD;
               tmr_r <= '0;
               hs_r <= 1'b0;
               ls_r <= 1'b1;
            end else if (st_r != PFS_OV_HOLD && (uv_trip || !run)) begin
               st_r <= PFS_OFF;
               hs_r <= 1'b0;
               ls_r <= 1'b0;
            end else begin
               unique case (st_r)
                  PFS_OFF: begin
                     hs_r <= 1'b0;
                     ls_r <= 1'b0;
                     st_r <= PFS_NORM;
                  end
                  PFS_NORM: begin
                     if (neg_s[gi] && ls_r) begin
                        st_r <= PFS_NEG_OFF;
                        tmr_r <= '0;
                        hs_r <= 1'b0;
                        ls_r <= 1'b0;
                     end else if (valley_s[gi] && !pwm_s[gi]) begin
                        st_r <= PFS_VALLEY;
                        hs_r <= 1'b0;
                        ls_r <= 1'b1;
                     end else begin
                        hs_r <= pwm_s[gi];
                        ls_r <= ~pwm_s[gi];
                     end
                  end
                  PFS_VALLEY: begin
                     hs_r <= 1'b0;
                     ls_r <= 1'b1;
                     if (!valley_s[gi]) begin
                        st_r <= PFS_NORM;
                     end
                  end
                  PFS_NEG_OFF: begin
                     tmr_r <= tmr_r + 1'b1;
                     if (tmr_r == NEG_OFF_LAST) begin
                        st_r <= PFS_NEG_ON;
                        ls_r <= 1'b1;
                     end
                  end
                  PFS_NEG_ON: begin
                     if (neg_s[gi]) begin
                        st_r <= PFS_NEG_OFF;
                        tmr_r <= '0;
                        ls_r <= 1'b0;
                     end else if (tgt_s[gi]) begin
                        st_r <= PFS_RESUME;
                        ls_r <= 1'b0;
                     end
                  end
                  PFS_RESUME: begin
                     // The dead cycle before the high side avoids shoot-through.
                     hs_r <= 1'b1;
                     st_r <= PFS_NORM;
                  end
                  PFS_OV_HOLD: begin
                     tmr_r <= tmr_r + 1'b1;
                     if (tmr_r == OV_HOLD_LAST) begin
                        st_r <= PFS_OFF;
                        ls_r <= 1'b0;
                     end
                  end
                  default: begin
                     st_r <= PFS_OFF;
                     hs_r <= 1'b0;
                     ls_r <= 1'b0;
                  end
               endcase
            end
         end

         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               en_r <= 1'b0;
               pg_r <= 1'b0;
            end else begin
               en_r <= run;
               pg_r <= strap_dis_r[gi] | (run & pg_s[gi]);
            end
         end

         assign HS_ON[gi] = hs_r;
         assign LS_ON[gi] = ls_r;
         assign BUCK_EN[gi] = en_r;
         assign PGOOD_OUT[gi] = pg_r;
         assign uv_lat[gi] = uv_r;
         assign ov_lat[gi] = ov_r;
         assign uv_ev[gi] = uv_trip & ~uv_r & (st_r != PFS_OV_HOLD);
         assign ov_ev[gi] = (st_r == PFS_OV_HOLD) & (tmr_r == OV_HOLD_LAST);
      end
   endgenerate

   // Ramp step divider shared by both soft starts.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == RAMP_DIV_LAST);
         div_r <= (div_r == RAMP_DIV_LAST) ? '0 : div_r + 1'b1;
      end
   end

   assign term_run = gate_ok & TERM_REQ & ~term_uv_r;
   assign lsw_run = gate_ok & sleep_s & LSW_REQ;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         term_uv_r <= 1'b0;
         TERM_EN <= 1'b0;
         TERM_RAMP <= 8'h00;
         TERM_DISCHARGE <= 1'b1;
      end else begin
         if (!ce_s) begin
            term_uv_r <= 1'b0;
         end else if (TERM_EN && term_uv_s) begin
            term_uv_r <= 1'b1;
         end
         TERM_EN <= term_run;
         if (!term_run) begin
            TERM_RAMP <= 8'h00;
         end else if (tick_r && TERM_RAMP != RAMP_FULL) begin
            TERM_RAMP <= TERM_RAMP + 8'h01;
         end
         TERM_DISCHARGE <= ~ce_s | term_uv_r;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         LSW_EN <= 1'b0;
         LSW_RAMP <= 8'h00;
         LSW_DISCHARGE <= 1'b1;
      end else begin
         LSW_EN <= lsw_run;
         if (!lsw_run) begin
            LSW_RAMP <= 8'h00;
         end else if (tick_r && LSW_RAMP != RAMP_FULL) begin
            LSW_RAMP <= LSW_RAMP + 8'h01;
         end
         LSW_DISCHARGE <= ~ce_s | ~sleep_s;
      end
   end

   // Bus slave: one wait cycle, then the access completes with waitrequest low.
   assign bus_req = AVS_READ | AVS_WRITE;
   assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                   {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign irq_clr = (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_IRQ) ?
                    (AVS_WRITEDATA[14:0] & wmask[14:0]) : 15'h0000;

   // A new event in the clearing cycle survives the clear.
   always_comb begin
      irq_nxt = irq_r & ~irq_clr;
      irq_nxt[IRQ_UV_LSB +: 6] = irq_nxt[IRQ_UV_LSB +: 6] | uv_ev;
      irq_nxt[IRQ_OV_LSB +: 6] = irq_nxt[IRQ_OV_LSB +: 6] | ov_ev;
      irq_nxt[IRQ_OTP] = irq_nxt[IRQ_OTP] | (hot_s & ~otp_r);
      irq_nxt[IRQ_TERM_UV] = irq_nxt[IRQ_TERM_UV] | (TERM_EN & term_uv_s & ~term_uv_r);
      irq_nxt[IRQ_TRIP] = irq_nxt[IRQ_TRIP] | trip_fall;
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_r <= IRQ_RESET;
         IRQ_N <= 1'b1;
      end else begin
         irq_r <= irq_nxt;
         IRQ_N <= ~(|irq_nxt);
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_r <= CTRL_RESET;
      end else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL &&
                   AVS_BYTEENABLE[0]) begin
         ctrl_r <= AVS_WRITEDATA[5:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0000_0000;
      end else begin
         AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
         if (AVS_READ && AVS_WAITREQUEST) begin
            unique case (AVS_ADDRESS)
               REG_CTRL: AVS_READDATA <= {26'h000_0000, ctrl_r};
               REG_STATUS: AVS_READDATA <= {15'h0000, shut_r, trip_r, armed_r, term_uv_r,
                                            otp_r, ov_lat, uv_lat};
               REG_IRQ: AVS_READDATA <= {17'h0_0000, irq_r};
               REG_STRAP: AVS_READDATA <= {22'h00_0000, MEMORY_RAIL_VSEL, 2'h0, strap_dis_r};
               default: AVS_READDATA <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** pfs_fault_strap_ctrl_assertions.sv ***
// Port checker of the fault and strap controller, bound to the design.
`timescale 1ns/1ns
`default_nettype none
module pfs_checker
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic CHIP_ENABLE_IN,
   input wire logic [5:0] NEG_LIMIT,
   input wire logic [5:0] UV_CMP,
   input wire logic TEMP_HOT,
   input wire logic SLEEP_STATE_IN,
   input wire logic THERMAL_TRIP_N,
   input wire logic [5:0] HS_ON,
   input wire logic [5:0] LS_ON,
   input wire logic [5:0] BUCK_EN,
   input wire logic TERM_DISCHARGE,
   input wire logic LSW_DISCHARGE,
   input wire logic SUSPEND_RESET_OUT_N,
   input wire logic PLATFORM_POWER_OK
);
   int uv_run_r;
   // Saturates so that a long fault cannot wrap the run length back into range.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) uv_run_r <= 0;
      else if (!UV_CMP[0] || !CHIP_ENABLE_IN) uv_run_r <= 0;
      else if (uv_run_r < 300) uv_run_r <= uv_run_r + 1;
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!ARST_N);
   property p_neg;
      $fell(LS_ON[0]) && ($past(NEG_LIMIT[0], 2) || $past(NEG_LIMIT[0], 3))
         |-> ##39 !LS_ON[0] ##1 LS_ON[0];
   endproperty
   a_neg: assert property (p_neg) else $error("neg off time");
   property p_uv; uv_run_r == 206 |-> !HS_ON[0] && !LS_ON[0]; endproperty
   a_uv: assert property (p_uv) else $error("uv trip");
   property p_otp; TEMP_HOT [*5] |-> !BUCK_EN; endproperty
   a_otp: assert property (p_otp) else $error("otp");
   property p_term; !CHIP_ENABLE_IN [*4] |-> TERM_DISCHARGE; endproperty
   a_term: assert property (p_term) else $error("term discharge");
   property p_lsw; (!SLEEP_STATE_IN || !CHIP_ENABLE_IN) [*4] |-> LSW_DISCHARGE; endproperty
   a_lsw: assert property (p_lsw) else $error("lsw discharge");
   property p_trip;
      $fell(THERMAL_TRIP_N) && SUSPEND_RESET_OUT_N && CHIP_ENABLE_IN
         |-> ##[1:4] !SUSPEND_RESET_OUT_N;
   endproperty
   a_trip: assert property (p_trip) else $error("trip reset");
   property p_pok; $fell(SUSPEND_RESET_OUT_N) && CHIP_ENABLE_IN |-> !PLATFORM_POWER_OK; endproperty
   a_pok: assert property (p_pok) else $error("trip power ok");
   property p_order;
      $fell(SUSPEND_RESET_OUT_N) && CHIP_ENABLE_IN && $past(CHIP_ENABLE_IN, 4) |-> $stable(BUCK_EN);
   endproperty
   a_order: assert property (p_order) else $error("trip order");
endmodule
bind pfs_fault_strap_ctrl pfs_checker chk_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
   .CHIP_ENABLE_IN(CHIP_ENABLE_IN), .NEG_LIMIT(NEG_LIMIT), .UV_CMP(UV_CMP),
   .TEMP_HOT(TEMP_HOT), .SLEEP_STATE_IN(SLEEP_STATE_IN), .THERMAL_TRIP_N(THERMAL_TRIP_N),
   .HS_ON(HS_ON), .LS_ON(LS_ON), .BUCK_EN(BUCK_EN), .TERM_DISCHARGE(TERM_DISCHARGE),
   .LSW_DISCHARGE(LSW_DISCHARGE), .SUSPEND_RESET_OUT_N(SUSPEND_RESET_OUT_N),
   .PLATFORM_POWER_OK(PLATFORM_POWER_OK));
`default_nettype wire

// *** pfs_host_model.sv ***
// Register host model: bus cycles and interrupt service.
`timescale 1ns/1ns
`default_nettype none
module pfs_host_model
   import pfs_pkg::*;
(
   input wire logic clk,
   input wire logic irq_n,
   input wire logic wait_req,
   input wire logic [31:0] rdata,
   output logic [3:0] addr,
   output logic rd,
   output logic wr,
   output logic [31:0] wdata,
   output logic [3:0] ben
);
   initial {addr, rd, wr, wdata, ben} = '0;
   // The request stands until the edge that sees the wait released.
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      {addr, wdata, ben, rd, wr} <= {a, d, 4'hf, !w, w};
      @(posedge clk);
      while (wait_req !== 1'h1 ? 1'h0 : 1'h1) @(posedge clk);
      q = rdata;
      {rd, wr} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic service(output logic [31:0] st);
      logic [31:0] d;
      st = '0;
      if (irq_n === 1'h0) begin
         xfer(1'h0, REG_IRQ, '0, st);
         xfer(1'h1, REG_IRQ, st, d);
      end
   endtask
endmodule
`default_nettype wire

// *** pfs_pkg.sv ***
// Constants, register map and state encodings for the power fault and strap controller.
package pfs_pkg;
   localparam int NUM_REG = 6;
   localparam int CLK_PERIOD_NS = 10;

   // Negative current limit off time; least time, rounded up.
   localparam int NEG_OFF_NS = 400;
   localparam int NEG_OFF_CYC = (NEG_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Low side hold after an over-voltage trip.
   localparam int OV_HOLD_US = 10;
   localparam int OV_HOLD_CYC = (OV_HOLD_US * 1000) / CLK_PERIOD_NS;
   // Deglitch times of the under- and over-voltage comparators.
   localparam int UV_DG_NS = 2000;
   localparam int UV_DG_CYC = (UV_DG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OV_DG_NS = 1000;
   localparam int OV_DG_CYC = (OV_DG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Time per soft-start ramp step.
   localparam int RAMP_STEP_NS = 1000;
   localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int TMR_W = 10;
   localparam int DG_W = 8;
   localparam int DIV_W = 7;
   localparam logic [TMR_W-1:0] NEG_OFF_LAST = TMR_W'(NEG_OFF_CYC - 1);
   localparam logic [TMR_W-1:0] OV_HOLD_LAST = TMR_W'(OV_HOLD_CYC - 1);
   localparam logic [DG_W-1:0] UV_DG_LAST = DG_W'(UV_DG_CYC - 1);
   localparam logic [DG_W-1:0] OV_DG_LAST = DG_W'(OV_DG_CYC - 1);
   localparam logic [DIV_W-1:0] RAMP_DIV_LAST = DIV_W'(RAMP_STEP_CYC - 1);
   localparam logic [7:0] RAMP_FULL = 8'hff;

   // Register byte offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ = 4'h8;
   localparam logic [3:0] REG_STRAP = 4'hc;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [14:0] IRQ_RESET = 15'h0000;

   // Interrupt status bit positions.
   localparam int IRQ_UV_LSB = 0;
   localparam int IRQ_OV_LSB = 6;
   localparam int IRQ_OTP = 12;
   localparam int IRQ_TERM_UV = 13;
   localparam int IRQ_TRIP = 14;

   // Memory rail target codes.
   localparam logic [1:0] MEM_1V2 = 2'h0;
   localparam logic [1:0] MEM_1V1 = 2'h1;
   localparam logic [1:0] MEM_1V35 = 2'h2;

   // Switching control states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      PFS_OFF = 3'b100,
      PFS_NORM = 3'b000,
      PFS_VALLEY = 3'b001,
      PFS_NEG_OFF = 3'b011,
      PFS_NEG_ON = 3'b010,
      PFS_RESUME = 3'b101,
      PFS_OV_HOLD = 3'b110
   } pfs_sw_t;
endpackage

// *** tb.sv ***
// Self-checking bench of the fault and strap controller.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pfs_pkg::*;
   logic clk, arst_n, en, hi, lo, hot, cool, treq, tuv, lreq, slp, trip_n, srdy, pokr;
   logic rd, wr, wreq, ten, tdis, len, ldis, srst_n, pok, irq_n;
   logic [2:0] cs, os;
   logic [5:0] pwm, val, neg, tgt, uv, ov, pg, hs, ls, buck, pgd, m;
   logic [3:0] addr, ben;
   logic [31:0] wd, rdat, q;
   logic [1:0] vsel;
   logic [7:0] tramp, lramp;
   logic [9:0] rows [5];
   int num_errors = 0;
   int n_tests = 0;
   int k;
   pfs_fault_strap_ctrl uut (.CLK_SYS(clk), .ARST_N(arst_n), .CHIP_ENABLE_IN(en),
      .CURRENT_SET_STRAP(cs), .OUTPUT_SENSE_STRAP(os), .MEMORY_RAIL_SEL_HI(hi),
      .MEMORY_RAIL_SEL_LO(lo), .PWM_ON(pwm), .VALLEY_OVER(val), .NEG_LIMIT(neg),
      .AT_TARGET(tgt), .UV_CMP(uv), .OV_CMP(ov), .PG_IN(pg), .TEMP_HOT(hot),
      .TEMP_COOL(cool), .TERM_REQ(treq), .TERM_UV_CMP(tuv), .LSW_REQ(lreq),
      .SLEEP_STATE_IN(slp), .THERMAL_TRIP_N(trip_n), .SUSPEND_READY(srdy),
      .POWER_OK_REQ(pokr), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(ben), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .HS_ON(hs), .LS_ON(ls), .BUCK_EN(buck), .PGOOD_OUT(pgd),
      .MEMORY_RAIL_VSEL(vsel), .TERM_EN(ten), .TERM_RAMP(tramp), .TERM_DISCHARGE(tdis),
      .LSW_EN(len), .LSW_RAMP(lramp), .LSW_DISCHARGE(ldis),
      .SUSPEND_RESET_OUT_N(srst_n), .PLATFORM_POWER_OK(pok), .IRQ_N(irq_n));
   pfs_host_model host (.clk(clk), .irq_n(irq_n), .wait_req(wreq), .rdata(rdat),
      .addr(addr), .rd(rd), .wr(wr), .wdata(wd), .ben(ben));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t: %s", $time, s);
      end
   endtask
   task automatic get(input logic [3:0] a);
      host.xfer(1'h0, a, '0, q);
   endtask
   task automatic put(input logic [3:0] a, input logic [31:0] d);
      host.xfer(1'h1, a, d, q);
   endtask
   task automatic conclude;
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      cyc(20000);
      num_errors++;
      conclude();
   end
   initial begin
      {arst_n, en, hi, lo, hot, treq, tuv, lreq, srdy, pokr, cs, os} = '0;
      {cool, slp, trip_n} = '1;
      {pwm, val, neg, tgt, uv, ov, pg} = '0;
      rows = '{{2'h2, 3'h1, 3'h0, MEM_1V35}, {2'h1, 3'h0, 3'h2, MEM_1V2},
         {2'h0, 3'h4, 3'h5, MEM_1V1}, {2'h3, 3'h0, 3'h0, MEM_1V35}, {2'h1, 6'h00, MEM_1V2}};
      cyc(20);
      arst_n <= 1'h1;
      cyc(2);
      get(REG_CTRL);
      chk(q[5:0], CTRL_RESET, "ctrl rst");
      get(REG_IRQ);
      chk({irq_n, q[14:0]}, {1'h1, IRQ_RESET}, "irq rst");
      for (k = 0; k < 5; k++) begin
         {hi, lo, cs, os} <= rows[k][9:2];
         en <= 1'h0;
         cyc(6);
         en <= 1'h1;
         cyc(8);
         m = {cs[2], os, cs[1:0]};
         chk({vsel, buck, pgd}, {rows[k][1:0], ~m, m}, "strap");
         get(REG_STRAP);
         chk(q[9:0], {rows[k][1:0], 2'h0, m}, "strap reg");
      end
      put(REG_CTRL, 32'h0000_002a);
      put(4'h6, 32'hffff_ffff);
      get(4'h6);
      chk(q, 32'h0000_0000, "unmapped");
      get(REG_CTRL);
      chk({buck, q}, {6'h15, 32'h0000_002a}, "ctrl");
      put(REG_CTRL, 32'h0000_0000);
      cyc(5);
      chk(ls[0], 1'h1, "ls idle");
      neg[0] <= 1'h1;
      cyc(3);
      neg[0] <= 1'h0;
      for (k = 0; k < 20 && ls[0] !== 1'h0; k++) cyc(1);
      for (k = 0; k < 100 && ls[0] !== 1'h1; k++) cyc(1);
      chk(k, NEG_OFF_CYC, "neg off");
      tgt[0] <= 1'h1;
      cyc(4);
      chk({hs[0], ls[0]}, 2'h0, "resume dead");
      cyc(1);
      chk({hs[0], ls[0]}, 2'h2, "resume hs");
      {tgt[0], val[0]} <= 2'h1;
      cyc(4);
      pwm[0] <= 1'h1;
      cyc(5);
      chk({hs[0], ls[0]}, 2'h1, "valley hold");
      val[0] <= 1'h0;
      cyc(5);
      chk({hs[0], ls[0]}, 2'h2, "valley end");
      {pwm, ov[1]} <= 7'h05;
      cyc(101);
      chk({hs[1], ls[1]}, 2'h2, "ov glitch");
      cyc(2);
      chk({hs[1], ls[1]}, 2'h1, "ov hold");
      cyc(999);
      chk({hs[1], ls[1]}, 2'h1, "ov hold end");
      cyc(1);
      chk({hs[1], ls[1]}, 2'h0, "ov latch");
      {pwm, ov[1]} <= 7'h00;
      host.service(q);
      chk({irq_n, q[IRQ_OV_LSB +: 2]}, 3'h6, "ov irq");
      uv[0] <= 1'h1;
      cyc(150);
      uv[0] <= 1'h0;
      cyc(5);
      get(REG_STATUS);
      chk({irq_n, q[0]}, 2'h2, "uv glitch");
      uv[0] <= 1'h1;
      cyc(230);
      uv[0] <= 1'h0;
      put(REG_IRQ, 32'h0000_0000);
      cyc(50);
      get(REG_STATUS);
      chk({hs[0], ls[0], irq_n, q[0]}, 4'h1, "uv latch");
      host.service(q);
      cyc(2);
      chk({irq_n, q[IRQ_UV_LSB]}, 2'h3, "uv irq");
      hot <= 1'h1;
      cyc(8);
      chk(buck, 6'h00, "otp");
      {hot, cool} <= 2'h0;
      cyc(8);
      chk(buck, 6'h00, "otp band");
      cool <= 1'h1;
      cyc(10);
      chk(buck, 6'h3c, "otp back");
      host.service(q);
      chk(q[IRQ_OTP], 1'h1, "otp irq");
      {treq, lreq} <= 2'h3;
      cyc(300);
      chk({ten, len, tdis, ldis}, 4'hc, "on");
      chk(tramp > 0 && tramp < 4 && lramp > 0 && lramp < 4, 1'h1, "ramp");
      slp <= 1'h0;
      cyc(5);
      chk({len, ldis}, 2'h1, "sleep");
      tuv <= 1'h1;
      cyc(300);
      tuv <= 1'h0;
      cyc(10);
      get(REG_STATUS);
      chk({ten, tdis, q[13]}, 3'h3, "term uv");
      en <= 1'h0;
      cyc(5);
      chk({tdis, ldis}, 2'h3, "en low");
      {en, slp} <= 2'h3;
      cyc(10);
      chk({ten, buck}, 7'h7f, "re-en");
      chk(tramp < 8'h02, 1'h1, "re-ramp");
      host.service(q);
      trip_n <= 1'h0;
      cyc(10);
      trip_n <= 1'h1;
      cyc(5);
      {srdy, pokr} <= 2'h3;
      cyc(10);
      chk({srst_n, pok, buck}, 8'hff, "unarmed");
      trip_n <= 1'h0;
      for (k = 0; k < 10 && srst_n !== 1'h0; k++) cyc(1);
      chk({k < 5, pok}, 2'h2, "trip");
      cyc(10);
      host.service(q);
      chk({buck, q[IRQ_TRIP]}, 7'h01, "trip off");
      conclude();
   end
endmodule
`default_nettype wire
